// File: common/adc_ctrl_params.svh
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define RESULT_ADDR 8'hd0
`define CONTROL_ADDR 8'hd1
`define IRQ_STATUS_ADDR 8'hd2
`define IRQ_MASK_ADDR 8'hd3

`define CTRL_IRQ_EN_BIT 7
`define CTRL_DONE_BIT 6
`define CTRL_START_BIT 5
`define CTRL_POWER_BIT 4
`define CTRL_OSC_OFF_BIT 2

`define CTRL_RESET 8'h40
`define CTRL_WRITE_MASK 8'h9f
`define RESULT_RESET 8'h00
`define MASK_RESET 8'h00

`define CLK_PERIOD_NS 25
`define SETTLE_TIME_NS 50
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STEP_WAIT_CYCLES 2

`endif

// File: common/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_SETTLE = 2'b01,
		SEQ_STEP = 2'b10
	} seq_state_t;

	typedef struct packed {
		logic conv_irq_enable;
		logic converter_power_on;
		logic reserved_bit_three;
		logic main_clock_disable;
		logic [1:0] reserved_low;
	} ctrl_fields_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// File: src/adc_conversion_control.sv
// Local design decision: the address-and-strobe port.
`include "adc_ctrl_params.svh"

// How it works
// - Converter runs in wait; wakes from wait; stop mode disables it and its wake.
// - Done flag clears only on start; writing zero there does nothing.
// - Control register resets to 40h: done set, all else zero.
// - Bit 7 gates the done-flag interrupt request; end-of-conversion status with mask bit 0 set requests one without it.
// - Finished conversion sets read-only done bit 6 and requests interrupt if enabled.
// - Writing start one clears done and the end-of-conversion status, and sets the start-seen status.
// - Result is valid only while done is one.
// - Bit 5 write-only start strobe; one starts a conversion, zero nothing.
// - Start during a conversion abandons it and begins anew.
// - Control read always shows zero in the start position.
// - Bit 4 switches converter power.
// - Bit 2 drives main oscillator disable of the clock system.
// - Result register at D0h, read only, bit 7 most significant.
// - Control at D1h read/write; bit 6 ignores writes, bit 5 reads zero.
// - Input at or above high reference gives FFh, at or below low gives 00h.
module adc_conversion_control #(
	parameter int RES_BITS = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic resetn_i,
	// Register port.
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Low power modes.
	input wire logic wait_mode_i,
	input wire logic stop_mode_i,
	// Comparator core.
	input wire logic cmp_above_i,
	output logic [RES_BITS-1:0] dac_code_o,
	output logic sample_o,
	output logic analog_enable_o,
	// System.
	output logic main_clock_disable_o,
	output logic irq_o,
	output logic wake_o
);

	// Width of the bit position counter, which runs from RES_BITS down to zero.
	localparam int BIT_W = $clog2(RES_BITS + 1);

	adc_ctrl_pkg::reg_req_t req;
	adc_ctrl_pkg::ctrl_fields_t ctrl_ff;
	adc_ctrl_pkg::seq_state_t state_ff;
	logic done_ff;
	logic [RES_BITS-1:0] result_ff;
	logic [RES_BITS-1:0] trial_ff;
	logic [BIT_W-1:0] bit_ff;
	logic [3:0] settle_ff;
	logic cmp_meta_ff;
	logic cmp_sync_ff;
	logic [1:0] irq_status_ff;
	logic [1:0] irq_mask_ff;
	logic [7:0] rdata_ff;
	logic irq_ff;
	logic wake_ff;
	logic dac_sample_ff;
	logic start_wr;
	logic conv_done;
	logic active;
	logic settle_over;
	logic step_due;
	logic [RES_BITS-1:0] step_bit;
	logic [RES_BITS-1:0] nxt_result;
	logic [7:0] ctrl_read;

	assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

	assign start_wr = req.wr && req.addr == `CONTROL_ADDR && req.wdata[`CTRL_START_BIT];

	assign active = ctrl_ff.converter_power_on && !stop_mode_i;

	// One-hot mask of the bit under trial; all zero once the count is spent.
	for (genvar gi = 0; gi < RES_BITS; gi++)
	begin : g_step
		assign step_bit[gi] = bit_ff == BIT_W'(gi + 1);
	end

	always_comb
	begin
		nxt_result = trial_ff;
		if (!cmp_sync_ff)
		begin
			nxt_result = trial_ff & ~step_bit;
		end
	end

	assign settle_over = settle_ff == 4'd0;
	assign step_due = state_ff == adc_ctrl_pkg::SEQ_STEP && settle_over && active;
	assign conv_done = step_due && bit_ff == BIT_W'(1) && !start_wr;

	// Comparator output comes from the analog domain and is synchronised.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			cmp_meta_ff <= 1'b0;
			cmp_sync_ff <= 1'b0;
		end
		else
		begin
			cmp_meta_ff <= cmp_above_i;
			cmp_sync_ff <= cmp_meta_ff;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ctrl_ff <= '0;
		end
		else if (req.wr && req.addr == `CONTROL_ADDR)
		begin
			ctrl_ff.conv_irq_enable <= req.wdata[`CTRL_IRQ_EN_BIT];
			ctrl_ff.converter_power_on <= req.wdata[`CTRL_POWER_BIT];
			ctrl_ff.reserved_bit_three <= req.wdata[3];
			ctrl_ff.main_clock_disable <= req.wdata[`CTRL_OSC_OFF_BIT];
			ctrl_ff.reserved_low <= req.wdata[1:0];
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			done_ff <= 1'(`CTRL_RESET >> `CTRL_DONE_BIT);
		end
		else if (start_wr)
		begin
			done_ff <= 1'b0;
		end
		else if (conv_done)
		begin
			done_ff <= 1'b1;
		end
	end

	// Settle counter: a wait before the first step and before each decision.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			settle_ff <= 4'd0;
		end
		else if (start_wr)
		begin
			settle_ff <= 4'(`SETTLE_CYCLES);
		end
		else if (active && state_ff != adc_ctrl_pkg::SEQ_IDLE)
		begin
			// Two extra cycles cover the comparator synchroniser delay.
			if (settle_over)
			begin
				settle_ff <= 4'(`STEP_WAIT_CYCLES);
			end
			else
			begin
				settle_ff <= settle_ff - 4'd1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff <= adc_ctrl_pkg::SEQ_IDLE;
		end
		else if (start_wr)
		begin
			state_ff <= adc_ctrl_pkg::SEQ_SETTLE;
		end
		else if (!active)
		begin
			state_ff <= adc_ctrl_pkg::SEQ_IDLE;
		end
		else
		begin
			case (state_ff)
				adc_ctrl_pkg::SEQ_IDLE:
				begin
					state_ff <= adc_ctrl_pkg::SEQ_IDLE;
				end
				adc_ctrl_pkg::SEQ_SETTLE:
				begin
					if (settle_over)
					begin
						state_ff <= adc_ctrl_pkg::SEQ_STEP;
					end
				end
				adc_ctrl_pkg::SEQ_STEP:
				begin
					if (settle_over && bit_ff == BIT_W'(1))
					begin
						state_ff <= adc_ctrl_pkg::SEQ_IDLE;
					end
				end
				default:
				begin
					state_ff <= adc_ctrl_pkg::SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			trial_ff <= '0;
			bit_ff <= '0;
		end
		else if (start_wr)
		begin
			trial_ff <= RES_BITS'(1) << (RES_BITS - 1);
			bit_ff <= BIT_W'(RES_BITS);
		end
		else if (step_due)
		begin
			trial_ff <= nxt_result | (step_bit >> 1);
			bit_ff <= bit_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			result_ff <= RES_BITS'(`RESULT_RESET);
		end
		else if (conv_done)
		begin
			result_ff <= nxt_result;
		end
	end

	// Interrupt status: bit 0 end of conversion, bit 1 start seen; a read clears, an event wins.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_status_ff <= 2'b00;
		end
		else
		begin
			if (req.rd && req.addr == `IRQ_STATUS_ADDR)
			begin
				irq_status_ff <= 2'b00;
			end
			if (start_wr)
			begin
				irq_status_ff <= 2'b10;
			end
			if (conv_done)
			begin
				irq_status_ff[0] <= 1'b1;
			end
		end
	end

	// Mask register, same layout as the status register.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_mask_ff <= 2'(`MASK_RESET);
		end
		else if (req.wr && req.addr == `IRQ_MASK_ADDR)
		begin
			irq_mask_ff <= req.wdata[1:0];
		end
	end

	assign ctrl_read = {ctrl_ff.conv_irq_enable, done_ff, 1'b0, ctrl_ff.converter_power_on,
		ctrl_ff.reserved_bit_three, ctrl_ff.main_clock_disable, ctrl_ff.reserved_low};

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rdata_ff <= '0;
		end
		else if (req.rd)
		begin
			case (req.addr)
				`RESULT_ADDR: rdata_ff <= 8'(result_ff);
				`CONTROL_ADDR: rdata_ff <= ctrl_read;
				`IRQ_STATUS_ADDR: rdata_ff <= {6'h00, irq_status_ff};
				`IRQ_MASK_ADDR: rdata_ff <= {6'h00, irq_mask_ff};
				default: rdata_ff <= 8'h00;
			endcase
		end
		else
		begin
			rdata_ff <= 8'h00;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			irq_ff <= 1'b0;
		end
		else
		begin
			irq_ff <= !stop_mode_i && ((ctrl_ff.conv_irq_enable && done_ff)
				|| |(irq_status_ff & irq_mask_ff));
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wake_ff <= 1'b0;
		end
		else
		begin
			wake_ff <= ctrl_ff.conv_irq_enable && done_ff && wait_mode_i && !stop_mode_i;
		end
	end

	// Busy indication towards the comparator core.
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			dac_sample_ff <= 1'b0;
		end
		else
		begin
			dac_sample_ff <= active && state_ff != adc_ctrl_pkg::SEQ_IDLE;
		end
	end

	assign rdata_o = rdata_ff;
	assign dac_code_o = trial_ff;
	assign sample_o = dac_sample_ff;
	assign analog_enable_o = ctrl_ff.converter_power_on;
	assign main_clock_disable_o = ctrl_ff.main_clock_disable;
	assign irq_o = irq_ff;
	assign wake_o = wake_ff;

endmodule // adc_conversion_control

// File: verification/adc_cmp_model.sv
module adc_cmp_model (
	// Trial code from the sequencer.
	input wire logic [7:0] dac_code_i,
	// Analog level in half steps.
	input wire logic [8:0] level_i,
	// Comparator decision.
	output logic above_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Half steps keep a code equal to the level on the kept side.
	// full scale ends
	assign above_o = level_i > {dac_code_i, 1'b0};
endmodule // adc_cmp_model

// File: verification/adc_ctrl_sva.sv
`include "adc_ctrl_params.svh"
module adc_ctrl_sva #(
	parameter int RES_BITS = 8
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic wait_mode_i,
	input wire logic stop_mode_i,
	input wire logic sample_o,
	input wire logic analog_enable_o,
	input wire logic main_clock_disable_o,
	input wire logic wake_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic ctl_wr;
	assign ctl_wr = wr_i && addr_i == `CONTROL_ADDR;
	a_osc_follows: assert property (ctl_wr |=> main_clock_disable_o == $past(wdata_i[2]))
		else $error("bad clock disable");
	a_power_follows: assert property (ctl_wr |=> analog_enable_o == $past(wdata_i[4]))
		else $error("bad power");
	a_unmapped_zero: assert property (rd_i && (addr_i < 8'hd0 || addr_i > 8'hd3) |=> !rdata_o)
		else $error("bad unmapped read");
	a_idle_zero: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("bad idle data");
	a_start_reads_zero: assert property (rd_i && addr_i == `CONTROL_ADDR |=> !rdata_o[5])
		else $error("start bit read");
	a_wake_in_wait: assert property (wake_o |-> $past(wait_mode_i) && !$past(stop_mode_i))
		else $error("bad wake");
	a_start_begins: assert property (ctl_wr && wdata_i[5] && wdata_i[4] && !stop_mode_i
		|-> ##[1:5] sample_o) else $error("no conversion");
	a_step_span: assert property ($rose(sample_o)
		|=> (sample_o || stop_mode_i || !analog_enable_o)[*8]) else $error("short conversion");
endmodule // adc_ctrl_sva
bind adc_conversion_control adc_ctrl_sva #(.RES_BITS(RES_BITS)) sva (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.wait_mode_i(wait_mode_i),
	.stop_mode_i(stop_mode_i),
	.sample_o(sample_o),
	.analog_enable_o(analog_enable_o),
	.main_clock_disable_o(main_clock_disable_o),
	.wake_o(wake_o)
);

// File: verification/adc_conversion_control_tb_top.sv
`include "adc_ctrl_params.svh"
module adc_conversion_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int IRQ = 3, WAKE = 2, PWR = 1, OSC = 0;
	logic clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
	logic wait_mode_i = 1'b0, stop_mode_i = 1'b0, cmp_above_i;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, dac_code_o, v;
	logic [8:0] level = 9'h000;
	logic sample_o, analog_enable_o, main_clock_disable_o, irq_o, wake_o;
	logic [3:0] outs;
	logic [15:0] n;
	logic [15:0] notes[$];
	int bad_count = 0;
	int checks = 0;
	assign outs = {irq_o, wake_o, analog_enable_o, main_clock_disable_o};
	initial forever #12.5 clk_i = ~clk_i;
	adc_conversion_control dut (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.wait_mode_i(wait_mode_i),
		.stop_mode_i(stop_mode_i),
		.cmp_above_i(cmp_above_i),
		.dac_code_o(dac_code_o),
		.sample_o(sample_o),
		.analog_enable_o(analog_enable_o),
		.main_clock_disable_o(main_clock_disable_o),
		.irq_o(irq_o),
		.wake_o(wake_o)
	);
	adc_cmp_model cmp (.dac_code_i(dac_code_o), .level_i(level), .above_o(cmp_above_i));
	task automatic miss(input string s);
		bad_count++;
		$display("unexpected at %0t: %s", $time, s);
	endtask
	task automatic cmp_read(input logic [7:0] got, want);
		checks++;
		if (got !== want) miss($sformatf("read %h not %h", got, want));
	endtask
	// Samples a flag once the updates of the next edge have landed.
	task automatic pin(input int i, input logic want);
		@(posedge clk_i);
		@(negedge clk_i);
		checks++;
		if (outs[i] !== want) miss($sformatf("flag %0d", i));
	endtask
	always @(posedge clk_i)
	begin
		rd_d <= rd_i;
		if (rd_d)
		begin
			n = notes.pop_front();
			cmp_read(rdata_o & n[15:8], n[7:0]);
		end
	end
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, want, mask = 8'hff);
		@(posedge clk_i);
		notes.push_back({mask, want & mask});
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
	endtask
	task automatic finish_wait;
		int k;
		k = 0;
		repeat (4) @(posedge clk_i);
		while (sample_o !== 1'b0 && k < 100)
		begin
			@(posedge clk_i);
			k++;
		end
		if (k == 100) miss("conversion hung");
		repeat (2) @(posedge clk_i);
	endtask
	task automatic convert(input logic [8:0] lv, input logic [7:0] ctl, want);
		level <= lv;
		wr(`CONTROL_ADDR, ctl | 8'h20);
		rd(`CONTROL_ADDR, ctl);
		finish_wait;
		rd(`CONTROL_ADDR, ctl | 8'h40);
		rd(`RESULT_ADDR, want);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#100us;
		miss("watchdog");
		conclude;
	end
	initial
	begin
		void'($urandom(12));
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd(`CONTROL_ADDR, 8'h40);
		rd(`RESULT_ADDR, 8'h00);
		rd(8'h7e, 8'h00);
		pin(OSC, 1'b0);
		$display("reset test done");
		wr(`CONTROL_ADDR, 8'h94);
		rd(`CONTROL_ADDR, 8'hd4);
		pin(OSC, 1'b1);
		pin(PWR, 1'b1);
		wr(`CONTROL_ADDR, 8'h10);
		rd(`CONTROL_ADDR, 8'h50);
		wr(`RESULT_ADDR, 8'h5a);
		rd(`RESULT_ADDR, 8'h00);
		$display("register test done");
		v = 8'($urandom_range(254, 1));
		convert(9'h1ff, 8'h90, 8'hff);
		pin(IRQ, 1'b1);
		convert(9'h000, 8'h90, 8'h00);
		convert({v, 1'b1}, 8'h90, v);
		wr(`CONTROL_ADDR, 8'h10);
		pin(IRQ, 1'b0);
		wr(`IRQ_MASK_ADDR, 8'h01);
		rd(`IRQ_STATUS_ADDR, 8'h03);
		pin(IRQ, 1'b0);
		convert(9'h101, 8'h10, 8'h80);
		pin(IRQ, 1'b1);
		rd(`IRQ_STATUS_ADDR, 8'h01, 8'h01);
		pin(IRQ, 1'b0);
		wr(`IRQ_MASK_ADDR, 8'h00);
		$display("conversion test done");
		wr(`CONTROL_ADDR, 8'hb0);
		level <= 9'h0b5;
		repeat (10) @(posedge clk_i);
		wr(`CONTROL_ADDR, 8'hb0);
		repeat (18) @(posedge clk_i);
		rd(`CONTROL_ADDR, 8'h90);
		finish_wait;
		rd(`RESULT_ADDR, 8'h5a);
		$display("restart test done");
		wait_mode_i <= 1'b1;
		convert(9'h1ff, 8'h90, 8'hff);
		pin(WAKE, 1'b1);
		@(posedge clk_i);
		stop_mode_i <= 1'b1;
		pin(WAKE, 1'b0);
		pin(IRQ, 1'b0);
		wr(`CONTROL_ADDR, 8'h00);
		pin(PWR, 1'b0);
		$display("power test done");
		repeat (3) @(posedge clk_i);
		conclude;
	end
endmodule // adc_conversion_control_tb_top
